// >>> scp_port.sv
// Notes on behaviour
// - Frame starts: select low, then clock rises.
// - Sixteen-bit instruction, then counted data bytes.
// - Count field 11 streams until select rises.
// - Select high between whole bytes stalls, except in a streaming data phase, which it ends.
// - Select high mid-byte aborts to new instruction.
// - Select high at power-up selects strap inputs.
// - Select tied low gives two-wire operation.
// - Two-wire streaming never ends until reset.
// - Reads turn data line around and drive registers.
// - Incoming data sampled on clock rising edge.
// - Drive after falling edge, release after rising.
// - Bit order MSB first, configurable to LSB.
// - Byte registers at documented configuration addresses.
// - Clock register defaults stabilizer on, commit copies the shadow to the active copy.
// - Only the clock register is buffered until transfer bit written.
// - Reset loads documented default register values.
module scp_port #(
  parameter logic [7:0] CHIP_ID = 8'h5c  // Arbitrary value.
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sdio,
  output logic            o_spi_sdio,
  output logic            o_spi_sdio_oe_n,
  output logic            o_strap_mode,
  output logic            o_strap_sclk,
  output logic            o_strap_sdio,
  output logic            o_duty_cycle_stabilizer,
  output logic      [3:0] o_channel_enable,
  output logic      [7:0] o_flex_res,
  output logic            o_lsb_first
);

  logic                  sclk_s;
  logic                  cs_n_s;
  logic                  sdio_s;
  logic                  sclk_q;
  logic                  sclk_rise;
  logic                  sclk_fall;
  scp_pkg::scp_phase_type phase;
  logic [3:0]            bit_cnt;
  logic [15:0]           instr;
  logic [15:0]           next_instr;
  logic [7:0]            data_sh;
  logic [7:0]            next_byte;
  logic                  rd;
  logic                  streaming;
  logic [1:0]            bytes_left;
  logic [12:0]           addr;
  logic                  wr_en;
  logic [12:0]           wr_addr;
  logic [7:0]            wr_data;
  logic [7:0]            rd_byte;
  logic                  last_bit;

  function automatic logic [15:0] shift16(input logic [15:0] old, input logic d,
                                          input logic lsb);
    shift16 = lsb ? {d, old[15:1]} : {old[14:0], d};
  endfunction : shift16

  function automatic logic [7:0] shift8(input logic [7:0] old, input logic d,
                                        input logic lsb);
    shift8 = lsb ? {d, old[7:1]} : {old[6:0], d};
  endfunction : shift8

  function automatic logic pick_bit(input logic [7:0] b, input logic [3:0] idx,
                                    input logic lsb);
    logic [2:0] i;
    i        = idx[2:0];
    pick_bit = lsb ? b[i] : b[3'h7 - i];
  endfunction : pick_bit

  scp_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clk  (i_clk),
    .i_async({i_spi_sclk, i_spi_cs_n, i_spi_sdio}),
    .o_sync ({sclk_s, cs_n_s, sdio_s})
  );

  scp_regs #(
    .CHIP_ID(CHIP_ID)
  ) u_regs (
    .i_clk                  (i_clk),
    .i_sys_rst              (i_sys_rst),
    .i_wr_en                (wr_en),
    .i_wr_addr              (wr_addr),
    .i_wr_data              (wr_data),
    .i_rd_addr              (addr),
    .o_rd_data              (rd_byte),
    .o_lsb_first            (o_lsb_first),
    .o_duty_cycle_stabilizer(o_duty_cycle_stabilizer),
    .o_channel_enable       (o_channel_enable),
    .o_flex_res             (o_flex_res)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_q;
  assign sclk_fall = !sclk_s && sclk_q;
  assign next_instr = shift16(instr, sdio_s, o_lsb_first);
  assign next_byte  = shift8(data_sh, sdio_s, o_lsb_first);
  assign last_bit   = phase == scp_pkg::PH_DATA && bit_cnt == scp_pkg::BYTE_LAST
                      && !streaming && bytes_left == 2'h0;

  // The strap level is caught while reset is held; pin levels reach it with no reset.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_strap_mode <= cs_n_s;
      o_strap_sclk <= 1'b0;
      o_strap_sdio <= 1'b0;
    end else begin
      o_strap_sclk <= o_strap_mode & sclk_s;
      o_strap_sdio <= o_strap_mode & sdio_s;
    end
  end

  // Frame sequencing. With select tied low nothing here ever sees it high, so a
  // streaming frame can only be left through reset.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || o_strap_mode) begin
      phase      <= scp_pkg::PH_INSTR;
      bit_cnt    <= 4'h0;
      instr      <= 16'h0000;
      data_sh    <= 8'h00;
      rd         <= 1'b0;
      streaming  <= 1'b0;
      bytes_left <= 2'h0;
      addr       <= 13'h0000;
    end else if (cs_n_s) begin
      if (bit_cnt[2:0] != 3'h0) begin
        phase   <= scp_pkg::PH_INSTR;
        bit_cnt <= 4'h0;
      end else if (phase == scp_pkg::PH_DATA && streaming) begin
        phase   <= scp_pkg::PH_INSTR;
        bit_cnt <= 4'h0;
      end
      // Otherwise the frame is stalled between bytes and resumes later.
    end else if (sclk_rise) begin
      case (phase)
        scp_pkg::PH_INSTR: begin
          instr <= next_instr;
          if (bit_cnt == scp_pkg::INSTR_LAST) begin
            phase      <= scp_pkg::PH_DATA;
            bit_cnt    <= 4'h0;
            rd         <= next_instr[scp_pkg::INSTR_RW_BIT];
            bytes_left <= next_instr[scp_pkg::INSTR_CNT_HI:scp_pkg::INSTR_CNT_LO];
            streaming  <= next_instr[scp_pkg::INSTR_CNT_HI:scp_pkg::INSTR_CNT_LO]
                          == scp_pkg::CNT_STREAM;
            addr       <= next_instr[12:0];
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        scp_pkg::PH_DATA: begin
          data_sh <= next_byte;
          if (bit_cnt == scp_pkg::BYTE_LAST) begin
            bit_cnt <= 4'h0;
            // Streaming walks down in MSB-first order and up in LSB-first order.
            addr    <= o_lsb_first ? addr + 13'h0001 : addr - 13'h0001;
            if (!streaming) begin
              if (bytes_left == 2'h0) begin
                phase <= scp_pkg::PH_INSTR;
              end else begin
                bytes_left <= bytes_left - 2'h1;
              end
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default: begin
          phase   <= scp_pkg::PH_INSTR;
          bit_cnt <= 4'h0;
        end
      endcase
    end
  end

  // Write strobe: one cycle, one clock after the last data bit is sampled.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_en   <= 1'b0;
      wr_addr <= 13'h0000;
      wr_data <= 8'h00;
    end else begin
      wr_en   <= !o_strap_mode && !cs_n_s && sclk_rise && !rd
                 && phase == scp_pkg::PH_DATA && bit_cnt == scp_pkg::BYTE_LAST;
      wr_addr <= addr;
      wr_data <= next_byte;
    end
  end

  // Readback drives only after a falling edge, so the controller has released the line.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || o_strap_mode) begin
      o_spi_sdio_oe_n <= 1'b1;
      o_spi_sdio      <= 1'b0;
    end else if (cs_n_s) begin
      o_spi_sdio_oe_n <= 1'b1;
    end else if (sclk_rise && rd && last_bit) begin
      o_spi_sdio_oe_n <= 1'b1;
    end else if (sclk_fall && rd && phase == scp_pkg::PH_DATA) begin
      o_spi_sdio_oe_n <= 1'b0;
      o_spi_sdio      <= pick_bit(rd_byte, bit_cnt, o_lsb_first);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_mid_byte_abort;
    cs_n_s && !o_strap_mode && bit_cnt[2:0] != 3'h0;
  endsequence

  sequence s_back_to_instr;
    phase == scp_pkg::PH_INSTR && bit_cnt == 4'h0;
  endsequence

  property p_mid_byte_abort;
    s_mid_byte_abort |=> s_back_to_instr;
  endproperty
  a_mid_byte_abort: assert property (p_mid_byte_abort)
    else $error("Select high mid-byte did not abort the frame.");

  property p_sample_on_rise;
    !sclk_rise && !cs_n_s |=> $stable(bit_cnt) && $stable(instr);
  endproperty
  a_sample_on_rise: assert property (p_sample_on_rise)
    else $error("Bit counter moved without a rising clock edge.");

  property p_stall_holds;
    cs_n_s && bit_cnt[2:0] == 3'h0 && !(phase == scp_pkg::PH_DATA && streaming)
      |=> $stable(phase) && $stable(addr) && $stable(bit_cnt);
  endproperty
  a_stall_holds: assert property (p_stall_holds)
    else $error("Frame state lost during a between-byte stall.");

  property p_stream_persists;
    phase == scp_pkg::PH_DATA && streaming && !cs_n_s |=> phase == scp_pkg::PH_DATA;
  endproperty
  a_stream_persists: assert property (p_stream_persists)
    else $error("Streaming ended while select was low.");

  property p_drive_after_fall;
    $fell(o_spi_sdio_oe_n) |-> $past(sclk_fall) && rd;
  endproperty
  a_drive_after_fall: assert property (p_drive_after_fall)
    else $error("Data line driven without a preceding falling edge.");

  property p_release_on_rise;
    $rose(o_spi_sdio_oe_n) |-> $past(sclk_rise) || $past(cs_n_s);
  endproperty
  a_release_on_rise: assert property (p_release_on_rise)
    else $error("Data line released at an unexpected moment.");

  property p_instr_to_data;
    phase == scp_pkg::PH_INSTR && bit_cnt == scp_pkg::INSTR_LAST && sclk_rise && !cs_n_s
      |=> phase == scp_pkg::PH_DATA && bit_cnt == 4'h0 && addr == $past(next_instr[12:0]);
  endproperty
  a_instr_to_data: assert property (p_instr_to_data)
    else $error("Instruction did not hand over to the data phase.");

  property p_strap_quiet;
    o_strap_mode |-> o_spi_sdio_oe_n && !wr_en;
  endproperty
  a_strap_quiet: assert property (p_strap_quiet)
    else $error("Serial port active while strapped.");

  property p_write_strobe_once;
    wr_en |=> !wr_en;
  endproperty
  a_write_strobe_once: assert property (p_write_strobe_once)
    else $error("Write strobe lasted longer than one cycle.");

  property p_drive_only_reading;
    !o_spi_sdio_oe_n |-> rd && phase == scp_pkg::PH_DATA;
  endproperty
  a_drive_only_reading: assert property (p_drive_only_reading)
    else $error("Data line driven outside the data phase of a read.");

  property p_frame_ends_on_count;
    last_bit && sclk_rise && !cs_n_s |=> s_back_to_instr;
  endproperty
  a_frame_ends_on_count: assert property (p_frame_ends_on_count)
    else $error("Counted frame did not end after its last byte.");

  property p_strap_outputs_idle;
    !o_strap_mode |-> !o_strap_sclk && !o_strap_sdio;
  endproperty
  a_strap_outputs_idle: assert property (p_strap_outputs_idle)
    else $error("Strap outputs moved while the serial port is in use.");

endmodule : scp_port

// >>> scp_pkg.sv
package scp_pkg;

  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;

  localparam logic [12:0] ADDR_PORT_CONFIG  = 13'h0000;
  localparam logic [12:0] ADDR_CHIP_ID      = 13'h0001;
  localparam logic [12:0] ADDR_FLEX_RES     = 13'h0004;
  localparam logic [12:0] ADDR_DEVICE_INDEX = 13'h0005;
  localparam logic [12:0] ADDR_GLOBAL_CLOCK = 13'h0009;
  localparam logic [12:0] ADDR_SHADOW_UPD   = 13'h00ff;

  localparam logic [7:0] RST_PORT_CONFIG  = 8'h18;
  localparam logic [7:0] RST_FLEX_RES     = 8'h0f;
  localparam logic [3:0] RST_DEVICE_INDEX = 4'hf;
  localparam logic [7:0] RST_GLOBAL_CLOCK = 8'h01;

  localparam int unsigned CFG_LSB_HI   = 6;
  localparam int unsigned CFG_LSB_LO   = 1;
  localparam int unsigned CFG_SRST_HI  = 5;
  localparam int unsigned CFG_SRST_LO  = 2;
  localparam int unsigned GCC_STAB_BIT = 0;
  localparam int unsigned UPD_BIT      = 0;

  localparam int unsigned INSTR_RW_BIT = 15;
  localparam int unsigned INSTR_CNT_HI = 14;
  localparam int unsigned INSTR_CNT_LO = 13;
  localparam logic [1:0]  CNT_STREAM   = 2'h3;
  localparam logic [3:0]  INSTR_LAST   = 4'hf;
  localparam logic [3:0]  BYTE_LAST    = 4'h7;

  typedef enum logic {PH_INSTR, PH_DATA} scp_phase_type;

endpackage : scp_pkg

// >>> scp_sync.sv
module scp_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             i_clk,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // No reset here, so that pin levels are already valid while reset is held.
  always_ff @(posedge i_clk) begin
    meta   <= i_async;
    o_sync <= meta;
  end

endmodule : scp_sync

// >>> scp_regs.sv
module scp_regs #(
  parameter logic [7:0] CHIP_ID = 8'h5c  // Arbitrary value.
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_wr_en,
  input  wire logic [12:0] i_wr_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic [12:0] i_rd_addr,
  output logic      [7:0]  o_rd_data,
  output logic             o_lsb_first,
  output logic             o_duty_cycle_stabilizer,
  output logic      [3:0]  o_channel_enable,
  output logic      [7:0]  o_flex_res
);

  logic [7:0] gcc_shadow;
  logic [7:0] gcc_active;
  logic       shadow_update_bit;
  logic       soft_rst;

  assign soft_rst = i_wr_en && i_wr_addr == scp_pkg::ADDR_PORT_CONFIG
                    && (i_wr_data[scp_pkg::CFG_SRST_HI] || i_wr_data[scp_pkg::CFG_SRST_LO]);

  // Unbuffered registers take effect at once.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || soft_rst) begin
      o_lsb_first      <= scp_pkg::RST_PORT_CONFIG[scp_pkg::CFG_LSB_HI];
      o_channel_enable <= scp_pkg::RST_DEVICE_INDEX;
      o_flex_res       <= scp_pkg::RST_FLEX_RES;
    end else if (i_wr_en) begin
      // Either mirrored copy selects the order, so it lands whatever order was used.
      if (i_wr_addr == scp_pkg::ADDR_PORT_CONFIG) begin
        o_lsb_first <= i_wr_data[scp_pkg::CFG_LSB_HI] | i_wr_data[scp_pkg::CFG_LSB_LO];
      end
      if (i_wr_addr == scp_pkg::ADDR_DEVICE_INDEX) begin
        o_channel_enable <= i_wr_data[3:0];
      end
      if (i_wr_addr == scp_pkg::ADDR_FLEX_RES) begin
        o_flex_res <= i_wr_data;
      end
    end
  end

  // Buffered register: shadow copy first, active copy on the transfer bit.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || soft_rst) begin
      gcc_shadow <= scp_pkg::RST_GLOBAL_CLOCK;
      gcc_active <= scp_pkg::RST_GLOBAL_CLOCK;
    end else begin
      if (i_wr_en && i_wr_addr == scp_pkg::ADDR_GLOBAL_CLOCK) begin
        gcc_shadow <= i_wr_data;
      end
      if (shadow_update_bit) begin
        gcc_active <= gcc_shadow;
      end
    end
  end

  // A new set in the cycle of the self clear wins over the clear.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || soft_rst) begin
      shadow_update_bit <= 1'b0;
    end else if (i_wr_en && i_wr_addr == scp_pkg::ADDR_SHADOW_UPD) begin
      shadow_update_bit <= i_wr_data[scp_pkg::UPD_BIT];
    end else if (shadow_update_bit) begin
      shadow_update_bit <= 1'b0;
    end
  end

  assign o_duty_cycle_stabilizer = gcc_active[scp_pkg::GCC_STAB_BIT];

  always_comb begin
    case (i_rd_addr)
      scp_pkg::ADDR_PORT_CONFIG:  o_rd_data = {1'b0, o_lsb_first, 4'h6, o_lsb_first, 1'b0};
      scp_pkg::ADDR_CHIP_ID:      o_rd_data = CHIP_ID;
      scp_pkg::ADDR_FLEX_RES:     o_rd_data = o_flex_res;
      scp_pkg::ADDR_DEVICE_INDEX: o_rd_data = {4'h0, o_channel_enable};
      scp_pkg::ADDR_GLOBAL_CLOCK: o_rd_data = gcc_shadow;
      scp_pkg::ADDR_SHADOW_UPD:   o_rd_data = {7'h00, shadow_update_bit};
      default:                    o_rd_data = 8'h00;
    endcase
  end

  property p_transfer_commits;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_wr_en && i_wr_addr == scp_pkg::ADDR_SHADOW_UPD && i_wr_data[0] && !soft_rst)
      ##1 !i_wr_en |=> (gcc_active == $past(gcc_shadow)) && !shadow_update_bit;
  endproperty
  a_transfer_commits: assert property (p_transfer_commits)
    else $error("Transfer bit did not commit shadow or did not clear.");

  property p_shadow_holds;
    @(posedge i_clk) disable iff (i_sys_rst)
      !shadow_update_bit && !soft_rst |=> $stable(gcc_active);
  endproperty
  a_shadow_holds: assert property (p_shadow_holds)
    else $error("Active clock register changed without a transfer.");

  property p_reset_defaults;
    @(posedge i_clk) $fell(i_sys_rst) |-> o_duty_cycle_stabilizer && !o_lsb_first
                                        && o_channel_enable == 4'hf;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Registers did not take their defaults after reset.");

endmodule : scp_regs

// >>> scp_ctl_model.sv
module scp_ctl_model (
  input  wire logic i_clk,
  input  wire logic i_sdio,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdo,
  output logic      o_sdo_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // Select starts low so that reset sees a serial port rather than pin straps.
  initial begin
    o_sclk   = 1'b0;
    o_cs_n   = 1'b0;
    o_sdo    = 1'b0;
    o_sdo_en = 1'b0;
  end

  task automatic half(input int n);
    repeat (n) @(negedge i_clk);
  endtask : half

  // Select moves without looking at the serial clock; shift leaves it low, but pins can leave it high.
  task automatic sel(input logic v);
    o_cs_n = v;
    if (v) begin
      o_sdo_en = 1'b0;
    end
    half(4);
  endtask : sel

  // Pin-strap levels for the secondary functions.
  task automatic pins(input logic sclk, input logic sdo);
    o_sclk   = sclk;
    o_sdo    = sdo;
    o_sdo_en = 1'b1;
    half(6);
  endtask : pins

  // One bit per 160 ns; read data is taken mid-high, after the device's turnaround settles.
  task automatic shift(input logic [15:0] val, input int n, input logic lsb,
                       input logic drv, output logic [15:0] got);
    int k;
    got = 16'h0000;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      o_sdo_en = drv;
      o_sdo = val[k];
      half(4);
      o_sclk = 1'b1;
      half(2);
      got[k] = i_sdio;
      half(2);
      o_sclk = 1'b0;
    end
  endtask : shift
endmodule : scp_ctl_model

// >>> tb_scp_port.sv
module tb_scp_port;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] TB_ID = 8'h3b;  // Arbitrary value.

  logic       clk;
  logic       rst;
  logic       sclk;
  logic       cs_n;
  logic       sdo;
  logic       sdo_en;
  logic       sdio_line;
  logic       d_sdio;
  logic       d_oe_n;
  logic       strap;
  logic       strap_sclk;
  logic       strap_sdio;
  logic       stab;
  logic       lsb_first;
  logic [3:0] chan;
  logic [7:0] flex;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  int         fails;
  int         compares;

  // The pin has a pull-down, so a line nobody drives reads low.
  assign sdio_line = !d_oe_n ? d_sdio : (sdo_en ? sdo : 1'b0);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  scp_port #(.CHIP_ID(TB_ID)) u_dut (
    .i_clk                   (clk),
    .i_sys_rst               (rst),
    .i_spi_sclk              (sclk),
    .i_spi_cs_n              (cs_n),
    .i_spi_sdio              (sdio_line),
    .o_spi_sdio              (d_sdio),
    .o_spi_sdio_oe_n         (d_oe_n),
    .o_strap_mode            (strap),
    .o_strap_sclk            (strap_sclk),
    .o_strap_sdio            (strap_sdio),
    .o_duty_cycle_stabilizer (stab),
    .o_channel_enable        (chan),
    .o_flex_res              (flex),
    .o_lsb_first             (lsb_first)
  );

  scp_ctl_model u_ctl (
    .i_clk    (clk),
    .i_sdio   (sdio_line),
    .o_sclk   (sclk),
    .o_cs_n   (cs_n),
    .o_sdo    (sdo),
    .o_sdo_en (sdo_en)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out;
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // The strap decision follows the select level held while reset is asserted.
  task automatic do_reset(input logic strap_lvl);
    rst = 1'b1;
    u_ctl.sel(strap_lvl);
    @(negedge clk);
    rst = 1'b0;
    if (!strap_lvl) begin
      u_ctl.sel(1'b1);
    end
    repeat (3) @(negedge clk);
  endtask : do_reset

  task automatic xfer(input logic rw, input logic [1:0] cnt, input logic [12:0] addr,
                      input int n, input logic lsb, input logic keep, input logic stall);
    logic [15:0] g;
    u_ctl.sel(1'b0);
    u_ctl.shift({rw, cnt, addr}, 16, lsb, 1'b1, g);
    for (int i = 0; i < n; i++) begin
      if (stall && i > 0) begin
        u_ctl.sel(1'b1);
        u_ctl.sel(1'b0);
      end
      u_ctl.shift({8'h00, wbuf[i]}, 8, lsb, !rw, g);
      rbuf[i] = g[7:0];
    end
    if (!keep) begin
      u_ctl.sel(1'b1);
    end
  endtask : xfer

  task automatic wr1(input logic [12:0] addr, input logic [7:0] data);
    wbuf[0] = data;
    xfer(1'b0, 2'b00, addr, 1, 1'b0, 1'b0, 1'b0);
  endtask : wr1

  task automatic rd_chk(input logic [12:0] addr, input logic [7:0] exp, input logic lsb);
    xfer(1'b1, 2'b00, addr, 1, lsb, 1'b0, 1'b0);
    check("read data", rbuf[0], exp);
    check("sdio released", d_oe_n, 1'b1);
  endtask : rd_chk

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    close_out();
  end

  initial begin
    logic [15:0] g;
    fails = 0;
    compares = 0;
    do_reset(1'b0);
    check("strap", strap, 1'b0);
    check("stabilizer", stab, 1'b1);
    check("chan", chan, 4'hf);
    check("flex", flex, 8'h0f);
    check("lsb", lsb_first, 1'b0);
    rd_chk(13'h0000, 8'h18, 1'b0);
    rd_chk(13'h0001, TB_ID, 1'b0);
    rd_chk(13'h0009, 8'h01, 1'b0);
    wr1(13'h0020, 8'h00);
    rd_chk(13'h0020, 8'h00, 1'b0);
    wr1(13'h0009, 8'h00);
    check("stabilizer", stab, 1'b1);
    rd_chk(13'h0009, 8'h00, 1'b0);
    wr1(13'h00ff, 8'h01);
    check("stabilizer", stab, 1'b0);
    rd_chk(13'h00ff, 8'h00, 1'b0);
    wr1(13'h0004, 8'h05);
    check("flex", flex, 8'h05);
    wbuf[0] = 8'h06;
    wbuf[1] = 8'h09;
    xfer(1'b0, 2'b01, 13'h0005, 2, 1'b0, 1'b0, 1'b1);
    check("chan", chan, 4'h6);
    check("flex", flex, 8'h09);
    // Select rises partway through the data byte, so the byte must never land.
    for (int c = 1; c < 8; c += 3) begin
      u_ctl.sel(1'b0);
      u_ctl.shift(16'h0004, 16, 1'b0, 1'b1, g);
      u_ctl.shift(16'h00ff, c, 1'b0, 1'b1, g);
      u_ctl.sel(1'b1);
      wr1(13'h0005, c[7:0]);
      check("flex", flex, 8'h09);
      check("chan", chan, c[3:0]);
    end
    xfer(1'b1, 2'b11, 13'h0005, 3, 1'b0, 1'b0, 1'b0);
    check("stream 0", rbuf[0], 8'h07);
    check("stream 1", rbuf[1], 8'h09);
    check("stream 2", rbuf[2], 8'h00);
    wr1(13'h0000, 8'h42);
    check("lsb", lsb_first, 1'b1);
    rd_chk(13'h0000, 8'h5a, 1'b1);
    wbuf[0] = 8'h18;
    xfer(1'b0, 2'b00, 13'h0000, 1, 1'b1, 1'b0, 1'b0);
    check("lsb", lsb_first, 1'b0);
    // Select stays low across both frames, as a two-wire controller would leave it.
    wbuf[0] = 8'h0a;
    xfer(1'b0, 2'b00, 13'h0004, 1, 1'b0, 1'b1, 1'b0);
    xfer(1'b1, 2'b00, 13'h0004, 1, 1'b0, 1'b1, 1'b0);
    u_ctl.sel(1'b1);
    check("flex", flex, 8'h0a);
    check("two wire read", rbuf[0], 8'h0a);
    // Soft reset through the configuration register restores every default.
    wr1(13'h0000, 8'h3c);
    check("flex", flex, 8'h0f);
    check("chan", chan, 4'hf);
    check("stabilizer", stab, 1'b1);
    do_reset(1'b1);
    check("strap", strap, 1'b1);
    for (int p = 0; p < 4; p++) begin
      u_ctl.pins(p[1], p[0]);
      check("strap sclk", strap_sclk, p[1]);
      check("strap sdio", strap_sdio, p[0]);
    end
    wr1(13'h0004, 8'h33);
    check("flex", flex, 8'h0f);
    close_out();
  end
endmodule : tb_scp_port
